// *** design/ufcip_pkg.sv ***
// constants for the uart flow control and interrupt priority block
package ufcip_pkg;
   // register offsets on the 3-bit host address
   localparam logic [2:0] ADDR_DIV_LO      = 3'h0;
   localparam logic [2:0] ADDR_DIV_HI      = 3'h1;
   localparam logic [2:0] ADDR_INT_EN      = 3'h1;
   localparam logic [2:0] ADDR_ENH_FEAT    = 3'h2;
   localparam logic [2:0] ADDR_INT_ID      = 3'h2;
   localparam logic [2:0] ADDR_FIFO_CTL    = 3'h2;
   localparam logic [2:0] ADDR_LINE_CTL    = 3'h3;
   localparam logic [2:0] ADDR_MODEM_CTL   = 3'h4;
   localparam logic [2:0] ADDR_FLOW_THR    = 3'h6;
   localparam logic [2:0] ADDR_TRIG_LVL    = 3'h7;
   localparam logic [2:0] ADDR_XOFF2       = 3'h7;
   localparam logic [2:0] ADDR_FIFO_READY  = 3'h7;
   // line control values that open the alternate register banks
   localparam logic [7:0] LINE_CTL_ENH_KEY = 8'hbf;
   localparam int         LINE_CTL_DIV_BIT = 7;
   // field positions
   localparam int IE_RX_DATA   = 0;
   localparam int IE_TX_EMPTY  = 1;
   localparam int IE_LINE_ERR  = 2;
   localparam int IE_MODEM     = 3;
   localparam int IE_SLEEP     = 4;
   localparam int IE_XOFF      = 5;
   localparam int IE_RTS       = 6;
   localparam int IE_CTS       = 7;
   localparam int EF_WR_EN     = 4;
   localparam int EF_SPECIAL   = 5;
   localparam int EF_AUTO_RTS  = 6;
   localparam int EF_AUTO_CTS  = 7;
   localparam int MC_RTS       = 1;
   localparam int MC_READY_EN  = 2;
   localparam int MC_LOOPBACK  = 4;
   localparam int MC_BANK_EN   = 6;
   localparam int MC_PRESCALE  = 7;
   localparam int FC_ENABLE    = 0;
   // masks of the bits guarded by the enhanced write enable
   localparam logic [7:0] INT_EN_LOCK_MASK   = 8'hf0;
   localparam logic [7:0] FIFO_CTL_LOCK_MASK = 8'h30;
   localparam logic [7:0] MODEM_CTL_LOCK_MASK = 8'he0;
   // reset values
   localparam logic [7:0] RST_BYTE     = 8'h00;
   // identification codes, low six bits
   localparam logic [5:0] ID_LINE_ERR  = 6'h06;
   localparam logic [5:0] ID_RX_TMO    = 6'h0c;
   localparam logic [5:0] ID_RX_DATA   = 6'h04;
   localparam logic [5:0] ID_TX_EMPTY  = 6'h02;
   localparam logic [5:0] ID_MODEM     = 6'h00;
   localparam logic [5:0] ID_XOFF      = 6'h10;
   localparam logic [5:0] ID_FLOW_CHG  = 6'h20;
   // fifo control trigger tables, indexed by the 2-bit code
   localparam logic [6:0] TX_TRIG_TAB [4] = '{7'd8, 7'd16, 7'd32, 7'd56};
   localparam logic [6:0] RX_TRIG_TAB [4] = '{7'd8, 7'd16, 7'd56, 7'd60};
   localparam int         FIFO_LVL_W  = 7;
endpackage

// *** design/ufcip_baud_gen.sv ***
// baud tick generator, 16-bit divisor with optional divide by four
`timescale 1ns/1ps
module ufcip_baud_gen (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [15:0] divisor,
   input  wire logic        prescale4,
   output logic             baud_tick
);
   typedef struct packed {
      logic [1:0]  pre;
      logic [15:0] cnt;
      logic        tick;
   } ufcip_baud_t;

   ufcip_baud_t q;
   ufcip_baud_t d;

   always_comb begin
      logic pre_done;
      pre_done = 1'b0;
      d        = q;
      d.tick   = 1'b0;
      pre_done = !prescale4 || (q.pre == 2'd3);
      d.pre    = prescale4 ? q.pre + 2'd1 : 2'd0;
      // a zero divisor stops the generator rather than ticking every cycle
      if (divisor == 16'h0000) begin
         d.cnt = 16'h0000;
      end else if (pre_done) begin
         if (q.cnt >= divisor - 16'h0001) begin
            d.cnt  = 16'h0000;
            d.tick = 1'b1;
         end else begin
            d.cnt = q.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign baud_tick = q.tick;

   property p_no_tick_zero;
      @(posedge clk) disable iff (!reset_n)
      (divisor == 16'h0000) && $stable(divisor) |=> !baud_tick;
   endproperty
   a_no_tick_zero: assert property (p_no_tick_zero)
      else $error("baud tick with zero divisor");
endmodule // ufcip_baud_gen

// *** design/ufcip_core.sv ***
// enhanced control, flow control and interrupt identification of one channel
// How it works
// - identification encodes top source, priorities one to four
// - xoff or special character at priority five
// - cts/rts going inactive at priority six
// - enhanced bits 3:0 select software flow mode
// - enhanced bit 4 unlocks guarded control bits
// - special character compare against second xoff
// - auto rts halts and resumes on thresholds
// - auto cts halts transmitter on high cts
// - baud divides by sixteen-bit two-byte divisor
// - divisor writable only while sleep disabled
// - flow threshold holds halt and resume levels
// - flow threshold writes need both enables
// - trigger register holds tx and rx levels
// - trigger register writes need both enables
// - zero trigger field falls back to fifo control
// - ready bits 0,1 flag enough tx space
// - ready bits 4,5 flag rx level or timeout
// - ready register at seven when enabled, no loopback
// - identification bit 0 low while interrupt pending
// - modem control bit 4 enables internal loopback
`timescale 1ns/1ps
module ufcip_core
   import ufcip_pkg::*;
#(
   parameter int LVL_W = ufcip_pkg::FIFO_LVL_W
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [1:0]       channel_select_n,
   input  wire logic [2:0]       addr,
   input  wire logic             wr_stb,
   input  wire logic             rd_stb,
   input  wire logic [7:0]       wr_data,
   output logic      [7:0]       rd_data,
   input  wire logic             line_err,
   input  wire logic             rx_timeout,
   input  wire logic             rx_timeout_b,
   input  wire logic [LVL_W-1:0] rx_level,
   input  wire logic [LVL_W-1:0] rx_level_b,
   input  wire logic [LVL_W-1:0] tx_space,
   input  wire logic [LVL_W-1:0] tx_space_b,
   input  wire logic             tx_empty_evt,
   input  wire logic             modem_chg,
   input  wire logic             xoff_rcvd,
   input  wire logic             rx_char_valid,
   input  wire logic [7:0]       rx_char,
   input  wire logic             tx_serial,
   input  wire logic             rx_pin,
   input  wire logic             cts_n_pin,
   output logic                  rx_serial,
   output logic                  rts_n_pin,
   output logic                  tx_halt,
   output logic [3:0]            sw_flow_mode,
   output logic [LVL_W-1:0]      tx_trigger,
   output logic [LVL_W-1:0]      rx_trigger,
   output logic                  irq_n,
   output logic                  baud_tick
);
   import ufcip_pkg::*;

   typedef struct packed {
      logic [7:0] line_control;
      logic [7:0] interrupt_enable;
      logic [7:0] fifo_control;
      logic [7:0] modem_control;
      logic [7:0] enhanced_feature_control;
      logic [7:0] divisor_low_byte;
      logic [7:0] divisor_high_byte;
      logic [7:0] flow_threshold;
      logic [7:0] fifo_trigger_level;
      logic [7:0] xoff2;
      logic [7:0] rd_data;
      logic [2:0] cts_s;
      logic [2:0] rx_s;
      logic       cts_n;
      logic       rx;
      logic       rts_n;
      logic       auto_rts_n;
      logic       special;
      logic       xoff;
      logic       cts_chg;
      logic       rts_chg;
      logic       irq_n;
   } ufcip_state_t;

   ufcip_state_t q;
   ufcip_state_t d;

   // fifo control trigger unless the level field is nonzero
   function automatic logic [LVL_W-1:0] eff_trig(
      input logic [3:0]       field,
      input logic [LVL_W-1:0] fallback
   );
      logic [LVL_W-1:0] lvl;
      lvl = LVL_W'({field, 2'b00});
      return (field == 4'h0) ? fallback : lvl;
   endfunction

   // levels held as level divided by four
   function automatic logic [LVL_W-1:0] times4(input logic [3:0] field);
      return LVL_W'({field, 2'b00});
   endfunction

   //////////////////////////////////////////////////////////////////////
   logic             sel_a;
   logic             sel_any;
   logic             enh_bank;
   logic             div_bank;
   logic             wr_en_enh;
   logic             bank_open;
   logic             loopback;
   logic             ready_vis;
   logic [LVL_W-1:0] tx_trig;
   logic [LVL_W-1:0] rx_trig;
   logic [5:0]       id_code;
   logic             pending;
   logic [7:0]       int_id;
   logic [7:0]       fifo_ready;
   logic             id_read;
   logic             cts_int_n;
   logic             special_hit;

   assign sel_a     = !channel_select_n[0];
   assign sel_any   = channel_select_n != 2'b11;
   assign enh_bank  = q.line_control == LINE_CTL_ENH_KEY;
   assign div_bank  = q.line_control[LINE_CTL_DIV_BIT] && !enh_bank;
   assign wr_en_enh = q.enhanced_feature_control[EF_WR_EN];
   assign loopback  = q.modem_control[MC_LOOPBACK];
   assign bank_open = wr_en_enh && q.modem_control[MC_BANK_EN];
   assign ready_vis = q.modem_control[MC_READY_EN] && !loopback;

   assign tx_trig = eff_trig(q.fifo_trigger_level[3:0],
                             TX_TRIG_TAB[q.fifo_control[5:4]]);
   assign rx_trig = eff_trig(q.fifo_trigger_level[7:4],
                             RX_TRIG_TAB[q.fifo_control[7:6]]);

   assign cts_int_n = loopback ? !q.modem_control[MC_RTS] : q.cts_n;
   assign special_hit = q.enhanced_feature_control[EF_SPECIAL]
                        && rx_char_valid && (rx_char == q.xoff2);

   //////////////////////////////////////////////////////////////////////
   // priority encoder
   always_comb begin
      pending = 1'b1;
      id_code = ID_MODEM;
      if (line_err && q.interrupt_enable[IE_LINE_ERR]) begin
         id_code = ID_LINE_ERR;
      end else if (rx_timeout && q.interrupt_enable[IE_RX_DATA]) begin
         id_code = ID_RX_TMO;
      end else if (rx_level >= rx_trig
                   && q.interrupt_enable[IE_RX_DATA]) begin
         id_code = ID_RX_DATA;
      end else if ((tx_empty_evt || tx_space >= tx_trig)
                   && q.interrupt_enable[IE_TX_EMPTY]) begin
         id_code = ID_TX_EMPTY;
      end else if (modem_chg && q.interrupt_enable[IE_MODEM]) begin
         id_code = ID_MODEM;
      end else if ((q.xoff || q.special)
                   && q.interrupt_enable[IE_XOFF]) begin
         id_code = ID_XOFF;
      end else if ((q.cts_chg && q.interrupt_enable[IE_CTS])
                   || (q.rts_chg && q.interrupt_enable[IE_RTS])) begin
         id_code = ID_FLOW_CHG;
      end else begin
         pending = 1'b0;
         id_code = ID_MODEM;
      end
   end

   assign int_id = {{2{q.fifo_control[FC_ENABLE]}},
                    id_code[5:1], !pending};

   assign fifo_ready = {2'b00,
                        rx_timeout_b || (rx_level_b > rx_trig),
                        rx_timeout || (rx_level > rx_trig),
                        2'b00,
                        tx_space_b >= tx_trig,
                        tx_space >= tx_trig};

   assign id_read = rd_stb && sel_a && !enh_bank && !div_bank
                    && addr == ADDR_INT_ID;

   //////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [7:0] rdv;
      rdv = 8'h00;
      d   = q;
      // pins pass three flops; a change counts when stages two and three agree
      d.cts_s = {q.cts_s[1:0], cts_n_pin};
      d.rx_s  = {q.rx_s[1:0], rx_pin};
      if (q.cts_s[1] == q.cts_s[2]) begin
         d.cts_n = q.cts_s[2];
      end
      if (q.rx_s[1] == q.rx_s[2]) begin
         d.rx = q.rx_s[2];
      end

      // register writes
      if (wr_stb && sel_a) begin
         if (addr == ADDR_LINE_CTL) begin
            d.line_control = wr_data;
         end else if (enh_bank) begin
            if (addr == ADDR_ENH_FEAT) begin
               d.enhanced_feature_control = wr_data;
            end else if (addr == ADDR_XOFF2) begin
               d.xoff2 = wr_data;
            end
         end else if (div_bank) begin
            if (!q.interrupt_enable[IE_SLEEP]) begin
               if (addr == ADDR_DIV_LO) begin
                  d.divisor_low_byte = wr_data;
               end else if (addr == ADDR_DIV_HI) begin
                  d.divisor_high_byte = wr_data;
               end
            end
         end else begin
            unique case (addr)
               ADDR_INT_EN: begin
                  d.interrupt_enable = wr_en_enh ? wr_data :
                     (q.interrupt_enable & INT_EN_LOCK_MASK)
                     | (wr_data & ~INT_EN_LOCK_MASK);
               end
               ADDR_FIFO_CTL: begin
                  d.fifo_control = wr_en_enh ? wr_data :
                     (q.fifo_control & FIFO_CTL_LOCK_MASK)
                     | (wr_data & ~FIFO_CTL_LOCK_MASK);
               end
               ADDR_MODEM_CTL: begin
                  d.modem_control = wr_en_enh ? wr_data :
                     (q.modem_control & MODEM_CTL_LOCK_MASK)
                     | (wr_data & ~MODEM_CTL_LOCK_MASK);
               end
               ADDR_FLOW_THR: begin
                  if (bank_open) begin
                     d.flow_threshold = wr_data;
                  end
               end
               ADDR_TRIG_LVL: begin
                  if (bank_open) begin
                     d.fifo_trigger_level = wr_data;
                  end
               end
               default: begin
               end
            endcase
         end
      end

      // register reads, data from a flop one cycle later
      if (rd_stb && sel_a && addr == ADDR_LINE_CTL) begin
         rdv = q.line_control;
      end else if (rd_stb && sel_a && enh_bank) begin
         if (addr == ADDR_ENH_FEAT) begin
            rdv = q.enhanced_feature_control;
         end else if (addr == ADDR_XOFF2) begin
            rdv = q.xoff2;
         end
      end else if (rd_stb && sel_a && div_bank) begin
         if (addr == ADDR_DIV_LO) begin
            rdv = q.divisor_low_byte;
         end else if (addr == ADDR_DIV_HI) begin
            rdv = q.divisor_high_byte;
         end
      end else if (rd_stb && sel_any && addr == ADDR_FIFO_READY
                   && ready_vis) begin
         rdv = fifo_ready;
      end else if (rd_stb && sel_a) begin
         unique case (addr)
            ADDR_INT_EN:    rdv = q.interrupt_enable;
            ADDR_INT_ID:    rdv = int_id;
            ADDR_MODEM_CTL: rdv = q.modem_control;
            ADDR_FLOW_THR:  rdv = bank_open ? q.flow_threshold : 8'h00;
            ADDR_TRIG_LVL:  rdv = bank_open ? q.fifo_trigger_level : 8'h00;
            default:        rdv = 8'h00;
         endcase
      end
      d.rd_data = rdv;

      // auto rts hysteresis; halt above resume is software's job
      if (rx_level >= times4(q.flow_threshold[3:0])) begin
         d.auto_rts_n = 1'b1;
      end else if (rx_level <= times4(q.flow_threshold[7:4])) begin
         d.auto_rts_n = 1'b0;
      end
      d.rts_n = q.enhanced_feature_control[EF_AUTO_RTS] ?
                d.auto_rts_n : !q.modem_control[MC_RTS];

      // sticky sources clear on identification read; a new event wins
      if (id_read) begin
         d.special = 1'b0;
         d.xoff    = 1'b0;
         d.cts_chg = 1'b0;
         d.rts_chg = 1'b0;
      end
      if (special_hit) begin
         d.special = 1'b1;
      end
      if (xoff_rcvd) begin
         d.xoff = 1'b1;
      end
      if (!q.cts_n && d.cts_n) begin
         d.cts_chg = 1'b1;
      end
      if (!q.rts_n && d.rts_n) begin
         d.rts_chg = 1'b1;
      end
      d.irq_n = !pending;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q         <= '0;
         q.cts_s   <= 3'b111;
         q.rx_s    <= 3'b111;
         q.cts_n   <= 1'b1;
         q.rx      <= 1'b1;
         q.rts_n   <= 1'b1;
         q.irq_n   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   //////////////////////////////////////////////////////////////////////
   assign rd_data      = q.rd_data;
   assign rx_serial    = loopback ? tx_serial : q.rx;
   assign rts_n_pin    = loopback ? 1'b1 : q.rts_n;
   assign tx_halt      = q.enhanced_feature_control[EF_AUTO_CTS]
                         && cts_int_n;
   assign sw_flow_mode = q.enhanced_feature_control[3:0];
   assign tx_trigger   = tx_trig;
   assign rx_trigger   = rx_trig;
   assign irq_n        = q.irq_n;

   ufcip_baud_gen u_baud (
      .clk       (clk),
      .reset_n   (reset_n),
      .divisor   ({q.divisor_high_byte, q.divisor_low_byte}),
      .prescale4 (q.modem_control[MC_PRESCALE]),
      .baud_tick (baud_tick)
   );

   //////////////////////////////////////////////////////////////////////
   property p_line_err_top;
      @(posedge clk) disable iff (!reset_n)
      line_err && q.interrupt_enable[IE_LINE_ERR] |-> id_code == ID_LINE_ERR;
   endproperty
   a_line_err_top: assert property (p_line_err_top)
      else $error("line error not top identification");

   property p_flow_chg_id;
      @(posedge clk) disable iff (!reset_n)
      $rose(q.cts_chg) && q.interrupt_enable[IE_CTS] && pending
      && id_code[4:0] == 5'h00 && !modem_chg |-> id_code == ID_FLOW_CHG;
   endproperty
   a_flow_chg_id: assert property (p_flow_chg_id)
      else $error("cts change not reported at level six");

   property p_pending_bit;
      @(posedge clk) disable iff (!reset_n)
      rd_stb && sel_a && !enh_bank && !div_bank && addr == ADDR_INT_ID
      |=> rd_data[0] == q.irq_n;
   endproperty
   a_pending_bit: assert property (p_pending_bit)
      else $error("identification bit 0 disagrees with pending");

   property p_lock_int_en;
      @(posedge clk) disable iff (!reset_n)
      wr_stb && sel_a && !enh_bank && !div_bank && addr == ADDR_INT_EN
      && !wr_en_enh |=> $stable(q.interrupt_enable[7:4]);
   endproperty
   a_lock_int_en: assert property (p_lock_int_en)
      else $error("guarded enable bits written while locked");

   property p_div_sleep;
      @(posedge clk) disable iff (!reset_n)
      q.interrupt_enable[IE_SLEEP] |=> $stable(q.divisor_low_byte)
                                      && $stable(q.divisor_high_byte);
   endproperty
   a_div_sleep: assert property (p_div_sleep)
      else $error("divisor changed during sleep");

   property p_thr_gate;
      @(posedge clk) disable iff (!reset_n)
      !bank_open |=> $stable(q.flow_threshold) && $stable(q.fifo_trigger_level);
   endproperty
   a_thr_gate: assert property (p_thr_gate)
      else $error("threshold written without both enables");

   property p_auto_rts;
      @(posedge clk) disable iff (!reset_n)
      q.enhanced_feature_control[EF_AUTO_RTS] && !loopback
      && rx_level >= times4(q.flow_threshold[3:0])
      && $stable(q.enhanced_feature_control) |=> rts_n_pin;
   endproperty
   a_auto_rts: assert property (p_auto_rts)
      else $error("rts not raised at halt level");

   property p_auto_cts;
      @(posedge clk) disable iff (!reset_n)
      q.enhanced_feature_control[EF_AUTO_CTS] && !loopback && q.cts_n
      |-> tx_halt;
   endproperty
   a_auto_cts: assert property (p_auto_cts)
      else $error("transmitter not halted on high cts");

   property p_special;
      @(posedge clk) disable iff (!reset_n)
      special_hit |=> q.special;
   endproperty
   a_special: assert property (p_special)
      else $error("special character match lost");

   property p_ready_zero;
      @(posedge clk) disable iff (!reset_n)
      rd_stb && sel_any && addr == ADDR_FIFO_READY && ready_vis
      && !enh_bank && !div_bank |=> rd_data[7:6] == 2'b00
                                    && rd_data[3:2] == 2'b00;
   endproperty
   a_ready_zero: assert property (p_ready_zero)
      else $error("unused ready bits not zero");

   property p_trig_override;
      @(posedge clk) disable iff (!reset_n)
      q.fifo_trigger_level[3:0] != 4'h0
      |-> tx_trigger == times4(q.fifo_trigger_level[3:0]);
   endproperty
   a_trig_override: assert property (p_trig_override)
      else $error("nonzero trigger field not used");
endmodule // ufcip_core

// *** test/ufcip_peer.sv ***
// serial peer model: drives the clear-to-send and receive lines from hold_off and line_bit
`timescale 1ns/1ps
module ufcip_peer (
   input  wire logic clk,
   input  wire logic hold_off,
   input  wire logic line_bit,
   output logic      cts_n_pin,
   output logic      rx_pin
);
   // pins move on the falling edge, away from the sampling edge
   always @(negedge clk) begin
      cts_n_pin <= hold_off;
      rx_pin    <= line_bit;
   end
endmodule // ufcip_peer

// *** test/tb_uart_flow_ctrl_irq_priority.sv ***
// self-checking bench for the flow control and interrupt core
`timescale 1ns/1ps
module tb_uart_flow_ctrl_irq_priority;
   import ufcip_pkg::*;
   logic clk = 0, reset_n = 0, wr_stb = 0, rd_stb = 0, hold_off = 0;
   logic [1:0] channel_select_n = 2'b10;
   logic [2:0] addr = 0;
   logic [7:0] wr_data = 0, rd_data, rx_char = 0, v;
   logic [6:0] rx_level = 0, rx_level_b = 0, tx_space = 0, tx_space_b = 0;
   logic [6:0] ttr, rtr, tx_trigger, rx_trigger;
   logic line_err = 0, rx_timeout = 0, rx_timeout_b = 0, tx_empty_evt = 0;
   logic modem_chg = 0, xoff_rcvd = 0, rx_char_valid = 0, tx_serial = 1;
   logic line_bit = 1;
   logic rx_serial, rts_n_pin, tx_halt, irq_n, baud_tick, cts_n_pin, rx_pin;
   logic [3:0] sw_flow_mode;
   logic [31:0] seed = 32'hd128f741;
   logic [7:0] ids [5] = '{8'h06, 8'h0c, 8'h02, 8'h00, 8'h01};
   // bit 7 expected rts_n, low bits fill level; 12 sits in the hysteresis
   logic [7:0] rts_tab [5] = '{8'h00, 8'h90, 8'h8c, 8'h08, 8'h0c};
   int bad_count = 0, comparisons = 0, cyc = 0, g;

   ufcip_core DUT (.clk, .reset_n, .channel_select_n, .addr, .wr_stb,
      .rd_stb, .wr_data, .rd_data, .line_err, .rx_timeout, .rx_timeout_b,
      .rx_level, .rx_level_b, .tx_space, .tx_space_b, .tx_empty_evt,
      .modem_chg, .xoff_rcvd, .rx_char_valid, .rx_char, .tx_serial, .rx_pin,
      .cts_n_pin, .rx_serial, .rts_n_pin, .tx_halt, .sw_flow_mode,
      .tx_trigger, .rx_trigger, .irq_n, .baud_tick);
   ufcip_peer peer (.clk, .hold_off, .line_bit, .cts_n_pin, .rx_pin);

   initial forever #12.5 clk = ~clk;
   // run needs under a thousand cycles; ceiling leaves wide margin
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         report_and_stop();
      end
   end
   //////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [6:0] trig(logic [3:0] f);
      return f != 0 ? {1'b0, f, 2'b00} : 7'h08;
   endfunction
   task automatic chk(logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] d);
      @(negedge clk);
      addr = a;
      wr_data = d;
      wr_stb = 1;
      @(negedge clk);
      wr_stb = 0;
   endtask
   task automatic rd(logic [2:0] a, logic [7:0] e);
      @(negedge clk);
      addr = a;
      rd_stb = 1;
      @(negedge clk);
      rd_stb = 0;
      chk(rd_data, e);
   endtask
   // cycles between two ticks; a silent generator trips the timeout
   task automatic gap(output int n);
      n = 0;
      @(posedge baud_tick);
      @(negedge clk);
      do begin
         @(negedge clk);
         n++;
      end while (baud_tick !== 1'b1 && n < 99);
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(negedge clk);
      reset_n = 1;
      wr(3, 8'h80);
      wr(0, 8'h04);
      wr(1, 8'h00);
      wr(3, 8'h00);
      gap(g);
      chk(8'(g), 8'h04);
      wr(1, 8'hff);
      rd(1, 8'h0f);
      wr(3, 8'hbf);
      wr(2, 8'h10);
      wr(3, 8'h00);
      wr(7, 8'h33);
      chk(tx_trigger, 8'h08);
      wr(6, 8'h99);
      wr(4, 8'h40);
      rd(6, 8'h00);
      wr(6, 8'h24);
      rd(6, 8'h24);
      // sleep set, so this divisor write must be dropped
      wr(1, 8'h10);
      wr(3, 8'h80);
      wr(0, 8'h09);
      wr(3, 8'h00);
      wr(1, 8'h0f);
      gap(g);
      chk(8'(g), 8'h04);
      repeat (8) begin
         v = 8'(rnd());
         wr(7, v);
         ttr = trig(v[3:0]);
         rtr = trig(v[7:4]);
         chk(tx_trigger, ttr);
         chk(rx_trigger, rtr);
      end
      wr(4, 8'h44);
      repeat (16) begin
         v = 8'(rnd());
         channel_select_n = {v[3], ~v[3]};
         {rx_timeout, rx_timeout_b} = v[1:0];
         rx_level = v[2] ? rtr : 7'(rnd() % 65);
         tx_space = v[2] ? ttr : 7'(rnd() % 65);
         rx_level_b = 7'(rnd() % 65);
         tx_space_b = 7'(rnd() % 65);
         rd(7, {2'b00, rx_level_b > rtr | rx_timeout_b,
            rx_level > rtr | rx_timeout, 2'b00, tx_space_b >= ttr,
            tx_space >= ttr});
      end
      channel_select_n = 2'b10;
      rx_level = 0;
      // leftover space would raise the tx source over the modem one
      tx_space = 0;
      for (int i = 0; i < 5; i++) begin
         {line_err, rx_timeout, tx_empty_evt, modem_chg} = 4'b1111 >> i;
         rd(2, ids[i]);
         chk(irq_n, i == 4);
      end
      wr(1, 8'h20);
      xoff_rcvd = 1;
      @(negedge clk);
      xoff_rcvd = 0;
      rd(2, 8'h10);
      rd(2, 8'h01);
      wr(3, 8'hbf);
      wr(7, 8'h5a);
      wr(2, 8'h30);
      wr(3, 8'h00);
      for (int i = 0; i < 2; i++) begin
         rx_char = 8'h5b - 8'(i);
         rx_char_valid = 1;
         @(negedge clk);
         rx_char_valid = 0;
         rd(2, i ? 8'h10 : 8'h01);
      end
      rd(2, 8'h01);
      wr(3, 8'hbf);
      wr(2, 8'hda);
      chk(sw_flow_mode, 8'h0a);
      wr(3, 8'h00);
      for (int i = 0; i < 5; i++) begin
         rx_level = rts_tab[i][6:0];
         repeat (3) @(negedge clk);
         chk(rts_n_pin, rts_tab[i][7]);
      end
      wr(1, 8'h80);
      hold_off = 1;
      repeat (6) @(negedge clk);
      chk(tx_halt, 8'h01);
      chk(irq_n, 8'h00);
      rd(2, 8'h20);
      rd(2, 8'h01);
      hold_off = 0;
      line_bit = 0;
      repeat (6) @(negedge clk);
      chk(tx_halt, 8'h00);
      chk(rx_serial, 8'h00);
      // pin back high so only the loop can show a low
      tx_serial = 0;
      line_bit = 1;
      tx_space = 7'd64;
      wr(4, 8'h14);
      repeat (6) @(negedge clk);
      chk(rx_serial, 8'h00);
      chk(rts_n_pin, 8'h01);
      chk(tx_halt, 8'h01);
      rd(7, 8'h00);
      report_and_stop();
   end
endmodule // tb_uart_flow_ctrl_irq_priority
